/* protect_map.vh */
// Overview of operation
// - data memory protected while bit 7 clear
// - boot region 000000-0001FF protected while bit 6 clear
// - block 1 writes refused while guard clear
// - block 0 writes refused while guard clear
// - unimplemented bits always read zero
// - bits keep programmed value across reset
`ifndef PROTECT_MAP_VH
`define PROTECT_MAP_VH
// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define OFS_CODE_PROTECT_DATA_BOOT 24'h30_0009
`define OFS_BLOCK_WRITE_PROTECT_LOW 24'h30_000a
`define BIT_DATA_MEM_READ_GUARD 7
`define BIT_BOOT_REGION_READ_GUARD 6
`define BIT_BLOCK1_WRITE_GUARD 1
`define BIT_BLOCK0_WRITE_GUARD 0
`define MASK_CODE_PROTECT 8'hc0
`define MASK_WRITE_PROTECT 8'h03
`define UNPROGRAMMED_BYTE 8'hff
// ----------------------------------------------------------------
// program address ranges
// ----------------------------------------------------------------
`define BOOT_LO 24'h00_0000
`define BOOT_HI 24'h00_01ff
`define BLK0_LO 24'h00_0200
`define BLK0_HI 24'h00_07ff
`define BLK1_LO 24'h00_0800
`define BLK1_HI 24'h00_0fff
`endif

/* range_check.v */
`timescale 1ns/1ps
`include "protect_map.vh"
// ----------------------------------------------------------------
// classifies a program address into protected regions
// ----------------------------------------------------------------
module range_check (
   input wire [23:0] addr,
   output wire in_boot,
   output wire in_blk0,
   output wire in_blk1
);
   // purely combinational; ranges do not overlap
   assign in_boot = (addr <= `BOOT_HI);
   assign in_blk0 = (addr >= `BLK0_LO) && (addr <= `BLK0_HI);
   assign in_blk1 = (addr >= `BLK1_LO) && (addr <= `BLK1_HI);
endmodule // range_check

/* protect_bits.v */
`timescale 1ns/1ps
`include "protect_map.vh"
// ----------------------------------------------------------------
// nonvolatile protection configuration bytes
// ----------------------------------------------------------------
module protect_bits (
   input wire clk_sys,
   input wire srst,
   input wire [23:0] addr,
   input wire [7:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output wire [7:0] rdata,
   input wire [23:0] prog_addr,
   input wire data_access,
   output wire data_mem_read_guard,
   output wire boot_region_read_guard,
   output wire block1_write_guard,
   output wire block0_write_guard,
   output wire code_read_blocked,
   output wire data_read_blocked,
   output wire prog_write_refused
);
   // models nonvolatile cells: no srst term, reset cannot touch them
   reg [7:0] cp_byte_ff;
   reg [7:0] wp_byte_ff;
   reg [7:0] rdata_ff;
   reg [7:0] nxt_cp_byte;
   reg [7:0] nxt_wp_byte;
   reg [7:0] nxt_rdata;
   wire hit_cp;
   wire hit_wp;
   wire in_boot;
   wire in_blk0;
   wire in_blk1;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // exact byte-address match, shared by write and read decode
   function reg_hit;
      input [23:0] a;
      input [23:0] ofs;
      begin
         reg_hit = (a == ofs);
      end
   endfunction

   // cell programming only pulls bits low; erase lives elsewhere
   function [7:0] program_cells;
      input [7:0] cells;
      input [7:0] data;
      input [7:0] mask;
      begin
         program_cells = cells & data & mask;
      end
   endfunction

   // unprogrammed state is all ones in the implemented bits, unimplemented bits zero (power-up model only)
   // erased reads one
   initial begin
      cp_byte_ff = `UNPROGRAMMED_BYTE & `MASK_CODE_PROTECT;
      wp_byte_ff = `UNPROGRAMMED_BYTE & `MASK_WRITE_PROTECT;
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // one decode per byte; no aliasing, every other address is unmapped
   assign hit_cp = reg_hit(addr, `OFS_CODE_PROTECT_DATA_BOOT);
   assign hit_wp = reg_hit(addr, `OFS_BLOCK_WRITE_PROTECT_LOW);

   // ----------------------------------------------------------------
   // programming: writes only clear bits, like cell programming
   // ----------------------------------------------------------------
   // held across reset
   always @* begin
      nxt_cp_byte = cp_byte_ff;
      nxt_wp_byte = wp_byte_ff;
      if (wr_stb && hit_cp) begin
         nxt_cp_byte = program_cells(cp_byte_ff, wdata, `MASK_CODE_PROTECT);
      end else if (wr_stb && hit_wp) begin
         nxt_wp_byte = program_cells(wp_byte_ff, wdata, `MASK_WRITE_PROTECT);
      end
   end

   // no srst term on purpose: a reset must never reopen a region
   always @(posedge clk_sys) begin
      cp_byte_ff <= nxt_cp_byte;
      wp_byte_ff <= nxt_wp_byte;
   end

   // ----------------------------------------------------------------
   // read port, data one cycle after the strobe
   // ----------------------------------------------------------------
   // unimplemented reads zero
   always @* begin
      nxt_rdata = 8'h00; // unmapped or idle reads zero
      if (rd_stb && hit_cp) begin
         nxt_rdata = cp_byte_ff & `MASK_CODE_PROTECT;
      end else if (rd_stb && hit_wp) begin
         nxt_rdata = wp_byte_ff & `MASK_WRITE_PROTECT;
      end
   end

   // read data stands one cycle only, then drops back to zero
   always @(posedge clk_sys) begin
      if (srst) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata = rdata_ff;

   assign data_mem_read_guard = cp_byte_ff[`BIT_DATA_MEM_READ_GUARD];
   assign boot_region_read_guard = cp_byte_ff[`BIT_BOOT_REGION_READ_GUARD];
   assign block1_write_guard = wp_byte_ff[`BIT_BLOCK1_WRITE_GUARD];
   assign block0_write_guard = wp_byte_ff[`BIT_BLOCK0_WRITE_GUARD];

   range_check u_range (
      .addr(prog_addr),
      .in_boot(in_boot),
      .in_blk0(in_blk0),
      .in_blk1(in_blk1)
   );

   // ----------------------------------------------------------------
   // protection decisions
   // ----------------------------------------------------------------
   // data memory guard
   assign data_read_blocked = data_access && !data_mem_read_guard;
   assign code_read_blocked = !data_access && in_boot &&
      !boot_region_read_guard;
   assign prog_write_refused = !data_access &&
      ((in_blk1 && !block1_write_guard) ||
       (in_blk0 && !block0_write_guard));
endmodule // protect_bits

/* protect_bits_sva.sv */
`timescale 1ns/1ps
// guard outputs against the stored bits
module protect_bits_sva (
   input wire clk_sys, srst, wr_stb, rd_stb, data_access,
   input wire [23:0] addr, prog_addr,
   input wire [7:0] rdata,
   input wire data_mem_read_guard, boot_region_read_guard,
   input wire block1_write_guard, block0_write_guard,
   input wire code_read_blocked, data_read_blocked, prog_write_refused
);
   wire [3:0] g = {data_mem_read_guard, boot_region_read_guard,
      block1_write_guard, block0_write_guard};
   wire [23:0] p = prog_addr;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   property p_dat; data_read_blocked == (data_access && !g[3]); endproperty
   a_dat: assert property (p_dat) else $error("data");
   property p_boot; code_read_blocked ==
      (!data_access && p < 24'h00_0200 && !g[2]); endproperty
   a_boot: assert property (p_boot) else $error("boot");
   property p_b1; !data_access && p[23:11] == 1
      |-> prog_write_refused == !g[1]; endproperty
   a_b1: assert property (p_b1) else $error("blk1");
   property p_b0; !data_access && p[23:11] == 0 && p > 24'h00_01ff
      |-> prog_write_refused == !g[0]; endproperty
   a_b0: assert property (p_b0) else $error("blk0");
   // a data-memory query never refuses a program write
   property p_pd; data_access |-> !prog_write_refused; endproperty
   a_pd: assert property (p_pd) else $error("pdata");
   property p_r9; $past(rd_stb) && $past(addr) == 24'h30_0009
      |-> rdata == {g[3:2], 6'h00}; endproperty
   a_r9: assert property (p_r9) else $error("rd9");
   property p_ra; $past(rd_stb) && $past(addr) == 24'h30_000a
      |-> rdata == {6'h00, g[1:0]}; endproperty
   a_ra: assert property (p_ra) else $error("rda");
   // bits move only on a programming write
   property p_keep; !wr_stb |=> $stable(g); endproperty
   a_keep: assert property (p_keep) else $error("keep");
   // programming can only clear a bit, never set it again
   property p_mono; wr_stb |=> (g & ~$past(g)) == 4'h0; endproperty
   a_mono: assert property (p_mono) else $error("mono");
   // cells ignore srst, so this one stays armed through reset
   property p_rst; disable iff (1'b0)
      srst && !wr_stb |=> $stable(g); endproperty
   a_rst: assert property (p_rst) else $error("rst");
endmodule // protect_bits_sva
bind protect_bits protect_bits_sva i_sva (.clk_sys, .srst, .wr_stb, .rd_stb,
   .data_access, .addr, .prog_addr, .rdata, .data_mem_read_guard,
   .boot_region_read_guard, .block1_write_guard, .block0_write_guard,
   .code_read_blocked, .data_read_blocked, .prog_write_refused);

/* test_protect_bits.sv */
`timescale 1ns/1ps
module test_protect_bits;
   logic clk_sys = 0, srst = 1, wr_stb = 0, rd_stb = 0, data_access = 0;
   logic [23:0] addr = 0, prog_addr = 0;
   logic [7:0] wdata = 0, rdata;
   wire dg, bg, g1, g0, cb, db, pw;
   int failures = 0, compares = 0;
   always #5 clk_sys = ~clk_sys;
   protect_bits i_protect_bits (.clk_sys, .srst, .addr, .wdata, .wr_stb,
      .rd_stb, .rdata, .prog_addr, .data_access, .data_mem_read_guard(dg),
      .boot_region_read_guard(bg), .block1_write_guard(g1),
      .block0_write_guard(g0), .code_read_blocked(cb),
      .data_read_blocked(db), .prog_write_refused(pw));
   task chk(string n, logic [7:0] e, logic [7:0] s);
      compares++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task wr(logic [23:0] a, logic [7:0] d);
      @(posedge clk_sys);
      {addr, wdata, wr_stb} <= {a, d, 1'b1};
      @(posedge clk_sys);
      wr_stb <= 0;
   endtask
   task rd(logic [23:0] a, logic [7:0] e);
      @(posedge clk_sys);
      {addr, rd_stb} <= {a, 1'b1};
      @(posedge clk_sys);
      rd_stb <= 0;
      #1 chk("rdata", e, rdata);
   endtask
   // flags are combinational, checked once settled
   task q(logic [23:0] a, logic d, logic [2:0] e);
      @(posedge clk_sys);
      {prog_addr, data_access} <= {a, d};
      #1 chk("flags", {5'h00, e}, {5'h00, cb, db, pw});
   endtask
   task tally_and_finish;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 0;
      rd(24'h30_0009, 8'hc0);
      rd(24'h30_000a, 8'h03);
      rd(24'h30_0008, 8'h00);
      // a write to an unmapped byte must not touch the cells
      wr(24'h30_0008, 8'h00);
      rd(24'h30_0009, 8'hc0);
      chk("guards", 8'h0f, {4'h0, dg, bg, g1, g0});
      q(24'h00_01ff, 1, 3'h0);
      q(24'h00_01ff, 0, 3'h0);
      wr(24'h30_0009, 8'h7f);
      q(24'h00_01ff, 1, 3'h2);
      q(24'h00_01ff, 0, 3'h0);
      wr(24'h30_0009, 8'hbf);
      wr(24'h30_0009, 8'hff);
      rd(24'h30_0009, 8'h00);
      q(24'h00_01ff, 0, 3'h4);
      q(24'h00_0200, 0, 3'h0);
      wr(24'h30_000a, 8'hfe);
      rd(24'h30_000a, 8'h02);
      q(24'h00_0200, 0, 3'h1);
      q(24'h00_07ff, 0, 3'h1);
      q(24'h00_0800, 0, 3'h0);
      wr(24'h30_000a, 8'hfd);
      q(24'h00_0fff, 0, 3'h1);
      q(24'h00_1000, 0, 3'h0);
      q(24'h00_0800, 1, 3'h2);
      // a second reset must leave the cells alone
      @(posedge clk_sys) srst <= 1;
      @(posedge clk_sys) srst <= 0;
      rd(24'h30_000a, 8'h00);
      chk("guards", 8'h00, {4'h0, dg, bg, g1, g0});
      q(24'h00_01ff, 1, 3'h2);
      q(24'h00_01ff, 0, 3'h4);
      tally_and_finish;
   end
   initial begin
      #20000;
      failures++;
      tally_and_finish;
   end
endmodule // test_protect_bits
